/* File: logic/axis_drive_regs.svh */
/*
 * Register map, field positions, reset values and pin indices of the
 * axis drive interface block.
 * Assumes a 32-bit Avalon-MM slave with byte addresses.
 */
`ifndef AXIS_DRIVE_REGS_SVH
`define AXIS_DRIVE_REGS_SVH
// Byte offsets of the registers.
`define REG_CTRL 5'h00
`define REG_STATUS 5'h04
`define REG_CMD 5'h08
`define REG_FB 5'h0c
`define REG_ERR 5'h10
`define REG_GEN 5'h14
`define REG_LATCH 5'h18
// Control register fields.
`define CTL_QUAD 0
`define CTL_MULT_LO 1
`define CTL_MULT_HI 2
`define CTL_FB_INT 3
`define CTL_INP_EN 4
`define CTL_FAULT_POL 5
`define CTL_INDEX_POL 6
`define CTL_HOME_POL 7
`define CTL_EMG_POL 8
`define CTL_GEN_LO 9
`define CTL_GEN_HI 10
`define CTL_DRV_EN 11
`define CTL_FLT_RST 12
`define CTL_ERCW_LO 16
`define CTL_ERCW_HI 23
`define CTL_RESET 32'h0010_0000
// Quadrature count rates.
`define MULT_X1 2'h0
`define MULT_X2 2'h1
// General counter sources.
`define GEN_CMD 2'h0
`define GEN_FB 2'h1
`define GEN_MAN 2'h2
// Pin indices in the synchronised input vector.
`define PIN_N 15
`define P_A 0
`define P_B 1
`define P_Z 2
`define P_INP 3
`define P_FLT 4
`define P_RDY 5
`define P_HOME 6
`define P_LIMP 7
`define P_LIMN 8
`define P_SLOW 9
`define P_PST 10
`define P_CAP 11
`define P_EMG 12
`define P_CLR 13
`define P_MAN 14
// Raw pin levels that read as inactive under the reset polarities.
`define PIN_IDLE 15'h1054
`endif

/* File: logic/axis_drive_pkg.sv */
/*
 * Types of the axis drive interface block.
 * Assumes the constants of axis_drive_regs.svh for its widths.
 */
`include "axis_drive_regs.svh"
package axis_drive_pkg;
    typedef enum logic [1:0] {B_IDLE, B_MOVE, B_SETTLE} busy_e;
    typedef struct packed {
        logic [`PIN_N-1:0] s1;
        logic [`PIN_N-1:0] s2;
        logic [`PIN_N-1:0] prev;
        logic [27:0] cmdCnt;
        logic [27:0] fbCnt;
        logic [27:0] genCnt;
        logic [27:0] latch;
        logic [15:0] errCnt;
        logic [31:0] ctrl;
        logic [31:0] rdata;
        logic [7:0] ercCnt;
        busy_e bst;
        logic busy;
        logic deviation_clear_out;
        logic inhibit;
        logic slow;
        logic pstart;
        logic home;
        logic homeDonePrev;
        logic halfTick;
        logic waitReq;
    } state_s;
endpackage

/* File: logic/axis_drive_io_feedback.sv */
/*
 * One axis of drive and switch interface logic: feedback, command,
 * error and general counters, busy tracking, fault and limit stops,
 * deviation clear pulse, and an Avalon-MM register slave.
 * Assumes a pulse generator on mclk that supplies command pulses,
 * move start, move done and home done, and obeys pulseInhibit.
 */
// The register offsets and the Avalon-MM slave port were decided locally.
`timescale 1ns/1ps
`include "axis_drive_regs.svh"
// Behaviour
// - A 28-bit up/down feedback counter counts the encoder phase inputs.
// - Feedback accepts dual-pulse or quadrature input, quadrature at x1, x2, x4.
// - Dual-pulse mode: phase A pulse counts up, phase B pulse counts down.
// - Quadrature counts up when A leads B, down when A lags.
// - Feedback source selects encoder or internal command pulses.
// - Encoder index polarity is configurable.
// - With in-position check on, busy holds until in-position is active.
// - With in-position check off, busy clears when all pulses are sent.
// - Active servo fault stops command pulses and sets fault status.
// - Servo fault polarity is configurable; wrong setting means permanent fault.
// - Deviation clear fires on home done, limit, servo fault, emergency.
// - Software drives a drive-enable output and a fault-reset output.
// - Drive ready is a readable input with no motion effect.
// - Switch inputs act in hardware within a few clock cycles.
// - Home switch polarity is configurable.
// - Stroke limit stops command pulses and fires deviation clear.
// - Slow-down input requests deceleration to start speed, both directions.
// - Position-start switch turning on requests a preset move.
// - Counter-clear input zeroes the counters.
// - Capture input copies the counter into a readable holding register.
// - Global emergency input stops motion at once.
// - Four counters; general counter source is selectable among four.
// - Command counter is 28-bit up/down, cleared by clear input or home done.
// - Error counter is 16-bit command minus feedback.
module axis_drive_io_feedback (
    input wire logic mclk, // Controller clock, 40 MHz.
    input wire logic rst_n, // Asynchronous reset, active low.
    input wire logic [4:0] avAddress, // Byte address.
    input wire logic avRead, // Read request.
    input wire logic avWrite, // Write request.
    input wire logic [3:0] avByteEnable, // Write byte lanes.
    input wire logic [31:0] avWriteData, // Write data.
    output logic [31:0] avReadData, // Read data.
    output logic avWaitRequest, // Stall, low for the answer.
    input wire logic encoderPhaseA, // Encoder phase A.
    input wire logic encoderPhaseB, // Encoder phase B.
    input wire logic encoderIndex, // Encoder index.
    input wire logic inPosition, // Drive in-position, active high.
    input wire logic servoFaultIn, // Drive fault, polarity set.
    input wire logic driveReady, // Drive ready, active high.
    input wire logic homeSwitch, // Home switch, polarity set.
    input wire logic strokeLimitPlus, // Plus limit, active high.
    input wire logic strokeLimitMinus, // Minus limit, active high.
    input wire logic slowdownSwitch, // Slow-down, active high.
    input wire logic positionStartSwitch, // Position start, active high.
    input wire logic captureSwitch, // Capture, active high.
    input wire logic emergencyHalt, // Emergency, polarity set.
    input wire logic countResetSwitch, // Counter clear, active high.
    input wire logic manualPulse, // Manual pulse input.
    input wire logic cmdPulse, // Command pulse emitted, one cycle.
    input wire logic cmdDir, // Command direction, high is plus.
    input wire logic moveStart, // Positioning command starts.
    input wire logic cmdDone, // All command pulses sent.
    input wire logic homeDone, // Home return completed.
    output logic busy, // Axis busy flag.
    output logic pulseInhibit, // Stop emitting command pulses.
    output logic deviationClearOut, // Deviation clear pulse.
    output logic slowdownReq, // Decelerate to start speed.
    output logic positionStartReq, // Start preset move, one cycle.
    output logic homeActive, // Home switch active level.
    output logic driveEnableOut, // Drive enable.
    output logic faultResetOut // Drive fault reset.
);
    axis_drive_pkg::state_s q;
    axis_drive_pkg::state_s next_q;
    logic [`PIN_N-1:0] pins;
    logic [`PIN_N-1:0] act;
    logic [`PIN_N-1:0] rise;
    logic [1:0] fbStep;
    logic [1:0] cmdStep;
    logic [1:0] genStep;
    logic [15:0] errExp;
    logic clrEdge;
    logic homeRise;
    logic wrTake;
    logic limitAct;
    logic ercTrig;

    // Merges write data into a register through the byte enables.
    function automatic logic [31:0] laneMerge(input logic [31:0] old,
            input logic [31:0] wd, input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // Applies an up/down step, encoded as {up, down}, to a counter.
    function automatic logic [27:0] applyStep(input logic [27:0] c,
            input logic [1:0] s);
        if (s == 2'b10) begin
            return c + 28'h0000001;
        end else if (s == 2'b01) begin
            return c - 28'h0000001;
        end
        return c;
    endfunction

    // Decodes one encoder sample pair into an up/down step.
    function automatic logic [1:0] encStep(input logic quad,
            input logic [1:0] mult, input logic a, input logic b,
            input logic pa, input logic pb);
        logic ea;
        logic eb;
        ea = a ^ pa;
        eb = b ^ pb;
        encStep = 2'b00;
        if (!quad) begin
            encStep = {a & ~pa, b & ~pb};
            if (encStep == 2'b11) begin
                encStep = 2'b00;
            end
        end else if (ea && (mult != `MULT_X1 || a)) begin
            encStep = (a != b) ? 2'b10 : 2'b01;
        end else if (eb && mult != `MULT_X1 && mult != `MULT_X2) begin
            encStep = (a == b) ? 2'b10 : 2'b01;
        end
    endfunction

    // Gathers the pins into one vector for the synchroniser.
    assign pins = {manualPulse, countResetSwitch, emergencyHalt,
        captureSwitch, positionStartSwitch, slowdownSwitch,
        strokeLimitMinus, strokeLimitPlus, homeSwitch, driveReady,
        servoFaultIn, inPosition, encoderIndex, encoderPhaseB,
        encoderPhaseA};

    // Active levels after polarity; a polarity bit set means active high.
    always_comb begin
        act = q.s2;
        act[`P_Z] = q.s2[`P_Z] ~^ q.ctrl[`CTL_INDEX_POL];
        act[`P_FLT] = q.s2[`P_FLT] ~^ q.ctrl[`CTL_FAULT_POL];
        act[`P_HOME] = q.s2[`P_HOME] ~^ q.ctrl[`CTL_HOME_POL];
        act[`P_EMG] = q.s2[`P_EMG] ~^ q.ctrl[`CTL_EMG_POL];
    end

    // Edge and event terms shared by the state update and the checks.
    assign rise = act & ~q.prev;
    assign clrEdge = rise[`P_CLR];
    assign homeRise = homeDone & ~q.homeDonePrev;
    assign wrTake = avWrite & ~q.waitReq;
    assign limitAct = act[`P_LIMP] | act[`P_LIMN];
    assign ercTrig = homeRise | rise[`P_LIMP] | rise[`P_LIMN]
        | rise[`P_FLT] | rise[`P_EMG];
    assign errExp = q.cmdCnt[15:0] - q.fbCnt[15:0];

    // Counter steps from the command pulses, feedback and general source.
    always_comb begin
        cmdStep = 2'b00;
        if (cmdPulse && !q.inhibit) begin
            cmdStep = cmdDir ? 2'b10 : 2'b01;
        end
        if (q.ctrl[`CTL_FB_INT]) begin
            fbStep = cmdStep;
        end else begin
            fbStep = encStep(q.ctrl[`CTL_QUAD],
                q.ctrl[`CTL_MULT_HI:`CTL_MULT_LO], act[`P_A], act[`P_B],
                q.prev[`P_A], q.prev[`P_B]);
        end
        case (q.ctrl[`CTL_GEN_HI:`CTL_GEN_LO])
            `GEN_CMD: genStep = cmdStep;
            `GEN_FB: genStep = fbStep;
            `GEN_MAN: genStep = {rise[`P_MAN], 1'b0};
            default: genStep = {q.halfTick, 1'b0};
        endcase
    end

    // Next state of the whole block.
    always_comb begin
        next_q = q;
        next_q.s1 = pins;
        next_q.s2 = q.s1;
        next_q.prev = act;
        next_q.homeDonePrev = homeDone;
        next_q.halfTick = ~q.halfTick;
        next_q.cmdCnt = applyStep(q.cmdCnt, cmdStep);
        next_q.fbCnt = applyStep(q.fbCnt, fbStep);
        next_q.genCnt = applyStep(q.genCnt, genStep);
        next_q.errCnt = errExp;
        if (rise[`P_CAP]) begin
            next_q.latch = q.fbCnt;
        end
        // Software writes to counters and control.
        if (wrTake) begin
            case (avAddress)
                `REG_CTRL: next_q.ctrl = laneMerge(q.ctrl, avWriteData,
                    avByteEnable);
                `REG_CMD: next_q.cmdCnt = 28'(laneMerge({4'h0, q.cmdCnt},
                    avWriteData, avByteEnable));
                `REG_FB: next_q.fbCnt = 28'(laneMerge({4'h0, q.fbCnt},
                    avWriteData, avByteEnable));
                `REG_GEN: next_q.genCnt = 28'(laneMerge({4'h0, q.genCnt},
                    avWriteData, avByteEnable));
                default: next_q.ctrl = q.ctrl;
            endcase
        end
        // The clear input and home completion win over counting.
        if (clrEdge || homeRise) begin
            next_q.cmdCnt = 28'h0000000;
        end
        if (clrEdge) begin
            next_q.fbCnt = 28'h0000000;
            next_q.genCnt = 28'h0000000;
        end
        // Stop conditions and switch requests.
        next_q.inhibit = act[`P_FLT] | limitAct | act[`P_EMG];
        next_q.slow = act[`P_SLOW];
        next_q.pstart = rise[`P_PST];
        next_q.home = act[`P_HOME];
        // Deviation clear pulse, restarted by each trigger.
        if (ercTrig) begin
            next_q.ercCnt = (q.ctrl[`CTL_ERCW_HI:`CTL_ERCW_LO] == 8'h00)
                ? 8'h01 : q.ctrl[`CTL_ERCW_HI:`CTL_ERCW_LO];
        end else if (q.ercCnt != 8'h00) begin
            next_q.ercCnt = q.ercCnt - 8'h01;
        end
        next_q.deviation_clear_out = next_q.ercCnt != 8'h00;
        // Busy tracking of a positioning command.
        case (q.bst)
            axis_drive_pkg::B_IDLE: begin
                if (moveStart) begin
                    next_q.bst = axis_drive_pkg::B_MOVE;
                end
            end
            axis_drive_pkg::B_MOVE: begin
                if (cmdDone) begin
                    if (q.ctrl[`CTL_INP_EN] && !act[`P_INP]) begin
                        next_q.bst = axis_drive_pkg::B_SETTLE;
                    end else begin
                        next_q.bst = axis_drive_pkg::B_IDLE;
                    end
                end
            end
            axis_drive_pkg::B_SETTLE: begin
                if (act[`P_INP]) begin
                    next_q.bst = axis_drive_pkg::B_IDLE;
                end
            end
            default: next_q.bst = axis_drive_pkg::B_IDLE;
        endcase
        if (moveStart) begin
            next_q.bst = axis_drive_pkg::B_MOVE;
        end
        next_q.busy = next_q.bst != axis_drive_pkg::B_IDLE;
        // Bus: one wait cycle, then the answer for one cycle.
        next_q.waitReq = !((avRead || avWrite) && q.waitReq);
        if (avRead && q.waitReq) begin
            case (avAddress)
                `REG_CTRL: next_q.rdata = q.ctrl;
                `REG_STATUS: next_q.rdata = {22'h000000, act[`P_EMG],
                    act[`P_SLOW], act[`P_LIMN], act[`P_LIMP],
                    act[`P_HOME], act[`P_Z], act[`P_RDY], act[`P_INP],
                    act[`P_FLT], q.busy};
                `REG_CMD: next_q.rdata = {4'h0, q.cmdCnt};
                `REG_FB: next_q.rdata = {4'h0, q.fbCnt};
                `REG_ERR: next_q.rdata = {16'h0000, q.errCnt};
                `REG_GEN: next_q.rdata = {4'h0, q.genCnt};
                `REG_LATCH: next_q.rdata = {4'h0, q.latch};
                default: next_q.rdata = 32'h00000000;
            endcase
        end
    end

    // State register.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
            q.s1 <= `PIN_IDLE; // Inactive levels, so reset makes no edge.
            q.s2 <= `PIN_IDLE;
            q.ctrl <= `CTL_RESET;
            q.waitReq <= 1'b1;
            q.bst <= axis_drive_pkg::B_IDLE;
        end else begin
            q <= next_q;
        end
    end

    // Outputs straight from the state register.
    assign avReadData = q.rdata;
    assign avWaitRequest = q.waitReq;
    assign busy = q.busy;
    assign pulseInhibit = q.inhibit;
    assign deviationClearOut = q.deviation_clear_out;
    assign slowdownReq = q.slow;
    assign positionStartReq = q.pstart;
    assign homeActive = q.home;
    assign driveEnableOut = q.ctrl[`CTL_DRV_EN];
    assign faultResetOut = q.ctrl[`CTL_FLT_RST];

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    // A clear edge on a quiet bus.
    sequence sClrEdge;
        clrEdge && !wrTake;
    endsequence

    // An isolated phase A pulse in dual-pulse external mode.
    sequence sDualUp;
        !q.ctrl[`CTL_QUAD] && !q.ctrl[`CTL_FB_INT] && rise[`P_A]
            && !rise[`P_B] && !clrEdge && !wrTake;
    endsequence

    AST_CLR_ZERO: assert property (sClrEdge |=>
        q.cmdCnt == 28'h0000000 && q.fbCnt == 28'h0000000)
        else $error("Counters not cleared by clear input.");
    AST_DUAL_UP: assert property (sDualUp |=>
        q.fbCnt == $past(q.fbCnt) + 28'h0000001)
        else $error("Dual-pulse A edge did not count up.");
    AST_ERR_DIFF: assert property (1'b1 |=>
        q.errCnt == $past(errExp))
        else $error("Error counter is not command minus feedback.");
    AST_CMD_UP: assert property ((cmdPulse && cmdDir && !q.inhibit
        && !clrEdge && !homeRise && !wrTake)
        |=> q.cmdCnt == $past(q.cmdCnt) + 28'h0000001)
        else $error("Command pulse not counted.");
    AST_FAULT_STOP: assert property (act[`P_FLT] |=> pulseInhibit)
        else $error("Fault did not inhibit pulses.");
    AST_LIMIT_ERC: assert property (rise[`P_LIMP] |=>
        deviationClearOut && pulseInhibit)
        else $error("Limit did not stop and clear deviation.");
    AST_SETTLE_BUSY: assert property ((q.bst == axis_drive_pkg::B_SETTLE
        && !act[`P_INP]) |=> busy)
        else $error("Busy dropped before in-position.");
    AST_NOINP_DONE: assert property ((q.bst == axis_drive_pkg::B_MOVE
        && cmdDone && !q.ctrl[`CTL_INP_EN] && !moveStart) |=> !busy)
        else $error("Busy held after pulses sent without check.");
    AST_CAPTURE: assert property (rise[`P_CAP] |=>
        q.latch == $past(q.fbCnt))
        else $error("Capture did not hold the feedback count.");
    AST_BUS_ANSWER: assert property (((avRead || avWrite) && q.waitReq)
        |=> !avWaitRequest ##1 avWaitRequest)
        else $error("Bus answer not one cycle after request.");

    // Stop, request, home and tracking checks.
    AST_EMG_STOP: assert property (act[`P_EMG] |=> pulseInhibit)
        else $error("Emergency did not inhibit pulses.");
    AST_SLOW_REQ: assert property (act[`P_SLOW] |=> slowdownReq)
        else $error("Slow-down request not raised.");
    AST_PSTART_ONE: assert property (rise[`P_PST] |=>
        positionStartReq ##1 !positionStartReq)
        else $error("Position start request is not a single pulse.");
    AST_HOME_ERC: assert property (homeRise |=>
        deviationClearOut && q.cmdCnt == 28'h0000000)
        else $error("Home completion did not clear and pulse.");
    AST_INT_TRACK: assert property ((q.ctrl[`CTL_FB_INT] && !homeRise
        && !clrEdge && !wrTake) |=> q.fbCnt - $past(q.fbCnt)
        == q.cmdCnt - $past(q.cmdCnt))
        else $error("Internal feedback did not track command count.");
endmodule

/* File: verification/drive_model.sv */
/*
 * Drive side model: encoder phases and the in-position answer.
 * Assumes the bench calls its tasks right after a rising mclk edge.
 */
`timescale 1ns/1ps
module drive_model #(
    parameter int SETTLE = 6
) (
    input wire logic mclk, // Controller clock.
    input wire logic inPosReq, // Motor has reached its target.
    output logic phaseA, // Encoder phase A.
    output logic phaseB, // Encoder phase B.
    output logic inPos // In-position answer, after SETTLE cycles.
);
    logic [1:0] q = 2'h0;
    int n = 0;
    // Lines start idle low.
    initial begin
        phaseA = 1'b0;
        phaseB = 1'b0;
    end
    // Quadrature steps; each edge is held four cycles to pass the syncs.
    task automatic quad(input logic up, input int cnt);
        repeat (cnt) begin
            q = up ? q + 2'h1 : q - 2'h1;
            phaseA <= q[0] ^ q[1];
            phaseB <= q[1];
            repeat (4) @(posedge mclk);
        end
    endtask
    // Plus or minus pulses, four cycles high and four low.
    task automatic dual(input logic onA, input int cnt);
        repeat (cnt) begin
            phaseA <= onA;
            phaseB <= !onA;
            repeat (4) @(posedge mclk);
            phaseA <= 1'b0;
            phaseB <= 1'b0;
            repeat (4) @(posedge mclk);
        end
    endtask
    // The drive settles a while after it is told it has arrived.
    always @(posedge mclk) begin
        n <= inPosReq ? (n < SETTLE ? n + 1 : n) : 0;
        inPos <= inPosReq && n == SETTLE;
    end
endmodule

/* File: verification/tb_top.sv */
/*
 * Self-checking bench of the axis drive block.
 * Assumes the design files and drive_model are compiled first.
 */
`timescale 1ns/1ps
`include "axis_drive_regs.svh"
module tb_top;
    logic mclk, rst_n, avRead, avWrite, avWaitRequest;
    logic [4:0] avAddress;
    logic [3:0] avByteEnable;
    logic [31:0] avWriteData, avReadData, c, d;
    logic encoderPhaseA, encoderPhaseB, encoderIndex, inPosition;
    logic servoFaultIn, driveReady, homeSwitch, strokeLimitPlus;
    logic strokeLimitMinus, slowdownSwitch, positionStartSwitch;
    logic captureSwitch, emergencyHalt, countResetSwitch, manualPulse;
    logic cmdPulse, cmdDir, moveStart, cmdDone, homeDone, busy, inPosReq;
    logic pulseInhibit, deviationClearOut, slowdownReq, positionStartReq;
    logic homeActive, driveEnableOut, faultResetOut;
    int err_count = 0;
    int cmp_count = 0;
    int n;
    axis_drive_io_feedback dut (.mclk, .rst_n, .avAddress, .avRead,
        .avWrite, .avByteEnable, .avWriteData, .avReadData,
        .avWaitRequest, .encoderPhaseA, .encoderPhaseB, .encoderIndex,
        .inPosition, .servoFaultIn, .driveReady, .homeSwitch,
        .strokeLimitPlus, .strokeLimitMinus, .slowdownSwitch,
        .positionStartSwitch, .captureSwitch, .emergencyHalt,
        .countResetSwitch, .manualPulse, .cmdPulse, .cmdDir, .moveStart,
        .cmdDone, .homeDone, .busy, .pulseInhibit, .deviationClearOut,
        .slowdownReq, .positionStartReq, .homeActive, .driveEnableOut,
        .faultResetOut);
    drive_model dm (.mclk, .inPosReq, .phaseA(encoderPhaseA),
        .phaseB(encoderPhaseB), .inPos(inPosition));
    // Controller clock, 25 ns period.
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    task automatic wt(input int k);
        repeat (k) @(posedge mclk);
    endtask
    task automatic chk(input string nm, input logic [31:0] e, g);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    // One bus cycle; the request is held until waitrequest is seen low.
    task automatic bus(input logic w, input logic [4:0] a,
            input logic [31:0] v);
        avAddress <= a;
        avWriteData <= v;
        avWrite <= w;
        avRead <= !w;
        do begin
            @(posedge mclk);
        end while (avWaitRequest !== 1'b0);
        d = avReadData;
        avWrite <= 1'b0;
        avRead <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic rdc(input logic [4:0] a, input logic [31:0] e,
            input string nm);
        bus(1'b0, a, 32'h0);
        chk(nm, e, d);
    endtask
    task automatic cp(input logic dir, input int k);
        repeat (k) begin
            cmdPulse <= 1'b1;
            cmdDir <= dir;
            @(posedge mclk);
            cmdPulse <= 1'b0;
            @(posedge mclk);
        end
    endtask
    // Waits for a deviation clear pulse and measures its width.
    task automatic ercw(input int w);
        int k;
        k = 0;
        n = 0;
        while (deviationClearOut !== 1'b1 && n < 12) begin
            @(posedge mclk);
            n++;
        end
        while (deviationClearOut === 1'b1 && k < 300) begin
            @(posedge mclk);
            k++;
        end
        chk("clear width", w, k);
    endtask
    task automatic trip(input int k, input logic v);
        case (k)
            0: servoFaultIn <= !v;
            1: strokeLimitPlus <= v;
            2: strokeLimitMinus <= v;
            default: emergencyHalt <= !v;
        endcase
    endtask
    task automatic end_sim;
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Cuts a hang short.
    initial begin
        wt(6000);
        err_count++;
        end_sim;
    end
    // Main sequence; fault, emergency and home pins idle inactive.
    initial begin
        {rst_n, avRead, avWrite, avAddress, avWriteData} = '0;
        {encoderIndex, servoFaultIn, emergencyHalt, homeSwitch} = 4'hf;
        {driveReady, strokeLimitPlus, strokeLimitMinus} = '0;
        {slowdownSwitch, positionStartSwitch, captureSwitch} = '0;
        {countResetSwitch, manualPulse, cmdPulse, cmdDir} = '0;
        {moveStart, cmdDone, homeDone, inPosReq} = '0;
        avByteEnable = 4'hf;
        wt(6);
        rst_n <= 1'b1;
        wt(2);
        rdc(`REG_CTRL, `CTL_RESET, "ctrl reset");
        rdc(5'h1c, 32'h0, "unmapped");
        c = 32'h0003_0000;
        bus(1'b1, `REG_CTRL, c | (1 << `CTL_DRV_EN));
        wt(1);
        chk("enable", 2, {driveEnableOut, faultResetOut});
        bus(1'b1, `REG_CTRL, c | (1 << `CTL_FLT_RST));
        wt(1);
        chk("enable", 1, {driveEnableOut, faultResetOut});
        bus(1'b1, `REG_CTRL, c);
        bus(1'b1, `REG_FB, 32'h0);
        dm.dual(1'b1, 3);
        dm.dual(1'b0, 1);
        wt(4);
        rdc(`REG_FB, 2, "fb dual");
        for (int m = 0; m < 3; m++) begin
            bus(1'b1, `REG_CTRL, c | 1 | (m << `CTL_MULT_LO));
            bus(1'b1, `REG_FB, 32'h0);
            dm.quad(1'b1, 4);
            wt(4);
            rdc(`REG_FB, 1 << m, "fb quad");
        end
        dm.quad(1'b0, 8);
        wt(4);
        rdc(`REG_FB, 32'h0fff_fffc, "fb reverse");
        bus(1'b1, `REG_CTRL, c | (1 << `CTL_FB_INT));
        bus(1'b1, `REG_FB, 32'h0);
        cp(1'b1, 5);
        wt(2);
        rdc(`REG_CMD, 5, "cmd");
        rdc(`REG_FB, 5, "fb internal");
        rdc(`REG_ERR, 0, "err");
        bus(1'b1, `REG_CTRL, c);
        cp(1'b0, 2);
        wt(2);
        rdc(`REG_ERR, 32'h0000_fffe, "err");
        rdc(`REG_GEN, 3, "gen cmd");
        captureSwitch <= 1'b1;
        wt(5);
        captureSwitch <= 1'b0;
        rdc(`REG_LATCH, 5, "latch");
        countResetSwitch <= 1'b1;
        wt(5);
        countResetSwitch <= 1'b0;
        rdc(`REG_CMD, 0, "cmd clear");
        rdc(`REG_FB, 0, "fb clear");
        rdc(`REG_GEN, 0, "gen clear");
        bus(1'b1, `REG_CTRL, c | (`GEN_MAN << `CTL_GEN_LO));
        repeat (2) begin
            manualPulse <= 1'b1;
            wt(4);
            manualPulse <= 1'b0;
            wt(4);
        end
        rdc(`REG_GEN, 2, "gen manual");
        bus(1'b1, `REG_CTRL, c);
        cp(1'b1, 4);
        homeDone <= 1'b1;
        wt(1);
        homeDone <= 1'b0;
        ercw(3);
        rdc(`REG_CMD, 0, "cmd home");
        for (int k = 0; k < 4; k++) begin
            trip(k, 1'b1);
            ercw(3);
            chk("inhibit", 1, pulseInhibit);
            bus(1'b0, `REG_STATUS, 32'h0);
            chk("fault status", k == 0, d[1]);
            trip(k, 1'b0);
            wt(5);
            chk("inhibit off", 0, pulseInhibit);
        end
        bus(1'b1, `REG_CTRL, c | (1 << `CTL_FAULT_POL));
        wt(4);
        chk("inhibit pol", 1, pulseInhibit);
        bus(1'b1, `REG_CTRL, c);
        wt(8);
        moveStart <= 1'b1;
        wt(1);
        moveStart <= 1'b0;
        wt(1);
        chk("busy", 1, busy);
        cmdDone <= 1'b1;
        wt(1);
        cmdDone <= 1'b0;
        wt(2);
        chk("busy", 0, busy);
        bus(1'b1, `REG_CTRL, c | (1 << `CTL_INP_EN));
        moveStart <= 1'b1;
        wt(1);
        moveStart <= 1'b0;
        cmdDone <= 1'b1;
        wt(1);
        cmdDone <= 1'b0;
        wt(6);
        chk("busy", 1, busy);
        inPosReq <= 1'b1;
        wt(15);
        chk("busy", 0, busy);
        inPosReq <= 1'b0;
        driveReady <= 1'b1;
        slowdownSwitch <= 1'b1;
        homeSwitch <= 1'b0;
        wt(5);
        chk("slow", 1, slowdownReq);
        chk("home", 1, homeActive);
        chk("ready side", 0, {busy, pulseInhibit});
        bus(1'b0, `REG_STATUS, 32'h0);
        chk("ready", 1, d[3]);
        chk("index", 0, d[4]);
        bus(1'b1, `REG_CTRL, c | 32'hc0);
        wt(4);
        chk("home pol", 0, homeActive);
        bus(1'b0, `REG_STATUS, 32'h0);
        chk("index pol", 1, d[4]);
        positionStartSwitch <= 1'b1;
        n = 0;
        repeat (8) begin
            @(posedge mclk);
            if (positionStartReq === 1'b1) n++;
        end
        chk("start pulses", 1, n);
        end_sim;
    end
endmodule
